// File: src/jcd_top.sv
// Two-controller scan chain with identification words and debug sync pin.
`timescale 1ns/10ps
`include "jcd_regs.svh"
// Operation
// - After reset each tile shows a boundary controller then a chip controller.
// - The boundary controller follows the standard state machine and scans pins.
// - The chip controller reaches tile, switch and one-time memory.
// - Test reset low keeps the whole scan logic in reset, indefinitely.
// - Output mode leaves debug pin floating, pulls it low at a breakpoint.
// - Input mode enters debug when an outside agent pulls the pin low.
// - Software chooses input or output use and enables each behaviour.
// - Identification instruction selects a 32-bit read-only identification word.
// - User-code instruction selects a 32-bit read-only user code word.
// - User ID field comes from security bits 31 to 22, zero when blank.
// - Global reset is active low and asserts asynchronously.
// - After reset release, boot starts only once the clock generator locks.
// - Security bit 0 blocks scan access to tile state and memory.
// - Security bit 13 refuses scan reads and writes of one-time memory.
// - Security bit 14 disables all use of the debug pin.
module jcd_top
  import jcd_pkg::*;
#(
  // Identity values below are arbitrary.
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_MAKER = 11'h155,
  parameter logic [`JCD_REV_W-1:0] SIL_REV = 18'h00001
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Scan pins.
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oen_o,
  // Debug synchronisation pin and its software controls.
  input wire logic debug_i,
  output logic debug_o,
  output logic debug_oen_o,
  input wire logic dbg_out_en_i,
  input wire logic dbg_in_en_i,
  input wire logic bp_hit_i,
  output logic dbg_req_o,
  // Security word and boot control.
  input wire logic [`JCD_DR_W-1:0] sec_reg_i,
  input wire logic pll_lock_i,
  input wire logic [1:0] boot_mode_i,
  output logic boot_go_o,
  output logic [1:0] boot_mode_o,
  // Chip access port towards tile, switch and one-time memory.
  output logic acc_valid_o,
  output logic [1:0] acc_tgt_o,
  output logic acc_wr_o,
  output logic [`JCD_ACC_W-2:0] acc_word_o,
  input wire logic [`JCD_DR_W-2:0] acc_rdata_i,
  // Boundary scan pins.
  input wire logic [`JCD_BSR_W-1:0] pins_i,
  output logic [`JCD_BSR_W-1:0] pins_o,
  output logic pins_oen_o
);
  localparam logic [`JCD_DR_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  // The debug pin idles high, so its synchroniser starts high and no request follows reset.
  localparam jcd_top_st_t TOP_RST = '{s1: `JCD_SYNC_RST, s2: `JCD_SYNC_RST, tdo_oen: 1'b1,
                                      dbg_oen: 1'b1, pin_oen: 1'b1, default: '0};

  jcd_top_st_t r_reg;
  jcd_top_st_t r_next;
  logic tck_rise;
  logic tck_fall;
  logic refuse;
  logic [`JCD_DR_W-1:0] user_word;

  jcd_tap_if bs_if ();
  jcd_tap_if ch_if ();

  // Boundary controller first, then the chip controller, in the chain.
  jcd_tap u_bs_tap (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .bus(bs_if.tap)
  );
  jcd_tap u_ch_tap (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .bus(ch_if.tap)
  );

  assign tck_rise = r_reg.s2[`JCD_SY_TCK] && !r_reg.tck_q;
  assign tck_fall = !r_reg.s2[`JCD_SY_TCK] && r_reg.tck_q;
  assign user_word = {sec_reg_i[`JCD_UID_MSB:`JCD_UID_LSB], {`JCD_UNUSED_W{1'b0}},
                      SIL_REV};

  assign bs_if.tck_rise = tck_rise;
  assign bs_if.tck_fall = tck_fall;
  assign bs_if.tms = r_reg.s2[`JCD_SY_TMS];
  assign bs_if.tdi = r_reg.s2[`JCD_SY_TDI];
  assign bs_if.trst_n = r_reg.s2[`JCD_SY_TRST];
  assign ch_if.tck_rise = tck_rise;
  assign ch_if.tck_fall = tck_fall;
  assign ch_if.tms = r_reg.s2[`JCD_SY_TMS];
  assign ch_if.tdi = bs_if.tdo;
  assign ch_if.trst_n = r_reg.s2[`JCD_SY_TRST];

  always_comb begin
    unique case (bs_if.ir)
      `JCD_IR_DEVICE_IDENTIFICATION_WORD: begin
        bs_if.dr_in = ID_WORD;
        bs_if.dr_len = `JCD_LEN_ID;
      end
      `JCD_IR_USERCODE: begin
        bs_if.dr_in = user_word;
        bs_if.dr_len = `JCD_LEN_ID;
      end
      `JCD_IR_EXTEST, `JCD_IR_SAMPLE: begin
        bs_if.dr_in = {{(`JCD_DR_W-`JCD_BSR_W){1'b0}}, r_reg.s2[`JCD_SYNC_W-1:`JCD_SY_PIN_LSB]};
        bs_if.dr_len = `JCD_LEN_BSR;
      end
      default: begin
        bs_if.dr_in = '0;
        bs_if.dr_len = `JCD_LEN_ONE;
      end
    endcase
    unique case (ch_if.ir)
      `JCD_IR_DEVICE_IDENTIFICATION_WORD: begin
        ch_if.dr_in = ID_WORD;
        ch_if.dr_len = `JCD_LEN_ID;
      end
      `JCD_IR_ACCESS: begin
        ch_if.dr_in = {r_reg.refused, acc_rdata_i};
        ch_if.dr_len = `JCD_LEN_ID;
      end
      default: begin
        ch_if.dr_in = '0;
        ch_if.dr_len = `JCD_LEN_ONE;
      end
    endcase
  end

  // Access word: target in the top two bits, then write flag, then payload.
  assign refuse = sec_reg_i[`JCD_SEC_NO_JTAG] ||
                  (sec_reg_i[`JCD_SEC_NO_OTP] &&
                   ch_if.dr_out[`JCD_DR_W-1 -: 2] == `JCD_TGT_OTP);

  always_comb begin
    r_next = r_reg;
    // Every pin passes two flops before use; only the second is looked at.
    r_next.s1 = {pins_i, boot_mode_i, pll_lock_i, debug_i, trst_n_i, tdi_i, tms_i, tck_i};
    r_next.s2 = r_reg.s1;
    r_next.tck_q = r_reg.s2[`JCD_SY_TCK];
    r_next.tdo = ch_if.tdo;
    r_next.tdo_oen = !(bs_if.shifting || ch_if.shifting);
    // Drive low only on a breakpoint; otherwise the pin floats high.
    r_next.dbg_oen = !(dbg_out_en_i && bp_hit_i &&
                       !sec_reg_i[`JCD_SEC_NO_DBG]);
    r_next.dbg_req = dbg_in_en_i && !r_reg.s2[`JCD_SY_DBG] &&
                     !sec_reg_i[`JCD_SEC_NO_DBG];
    if (!r_reg.boot_go && r_reg.s2[`JCD_SY_LOCK]) begin
      r_next.boot_go = 1'b1;
      r_next.boot_mode = r_reg.s2[`JCD_SY_MODE_LSB +: 2];
    end
    r_next.acc_valid = 1'b0;
    if (ch_if.update_dr && ch_if.ir == `JCD_IR_ACCESS) begin
      r_next.acc_valid = !refuse;
      r_next.refused = refuse;
      r_next.acc_tgt = ch_if.dr_out[`JCD_DR_W-1 -: 2];
      r_next.acc_wr = ch_if.dr_out[`JCD_ACC_W-1];
      r_next.acc_word = ch_if.dr_out[`JCD_ACC_W-2:0];
    end
    if (bs_if.update_dr && (bs_if.ir == `JCD_IR_EXTEST || bs_if.ir == `JCD_IR_SAMPLE)) begin
      r_next.bsr = bs_if.dr_out[`JCD_BSR_W-1:0];
    end
    r_next.pin_oen = (bs_if.ir != `JCD_IR_EXTEST);
    if (!r_reg.s2[`JCD_SY_TRST]) begin
      r_next.pin_oen = 1'b1;
      r_next.acc_valid = 1'b0;
    end
  end

  // Assertion of the global reset is immediate; release waits for a clock edge.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tdo_o = r_reg.tdo;
  assign tdo_oen_o = r_reg.tdo_oen;
  assign debug_o = 1'b0;
  assign debug_oen_o = r_reg.dbg_oen;
  assign dbg_req_o = r_reg.dbg_req;
  assign boot_go_o = r_reg.boot_go;
  assign boot_mode_o = r_reg.boot_mode;
  assign acc_valid_o = r_reg.acc_valid;
  assign acc_tgt_o = r_reg.acc_tgt;
  assign acc_wr_o = r_reg.acc_wr;
  assign acc_word_o = r_reg.acc_word;
  assign pins_o = r_reg.bsr;
  assign pins_oen_o = r_reg.pin_oen;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_trst_low;
    !r_reg.s2[`JCD_SY_TRST] ##1 !r_reg.s2[`JCD_SY_TRST];
  endsequence
  sequence s_sec_steady(int b);
    sec_reg_i[b] ##1 sec_reg_i[b];
  endsequence

  property p_trst_hold;
    s_trst_low |-> (bs_if.tlr && ch_if.tlr && pins_oen_o && !acc_valid_o);
  endproperty
  a_trst_hold: assert property (p_trst_hold) else $error("scan logic left reset");

  property p_chain_ir;
    s_trst_low |-> (bs_if.ir == `JCD_IR_DEVICE_IDENTIFICATION_WORD && ch_if.ir == `JCD_IR_DEVICE_IDENTIFICATION_WORD);
  endproperty
  a_chain_ir: assert property (p_chain_ir) else $error("chain not in reset form");

  property p_id_word;
    (bs_if.capture_dr && bs_if.ir == `JCD_IR_DEVICE_IDENTIFICATION_WORD) |=>
      (bs_if.dr_out == {ID_VERSION, ID_PART, ID_MAKER, 1'b1} && bs_if.dr_out[0]);
  endproperty
  a_id_word: assert property (p_id_word) else $error("bad identification word");

  property p_user_word;
    (bs_if.capture_dr && bs_if.ir == `JCD_IR_USERCODE) |=>
      (bs_if.dr_out[31:22] == $past(sec_reg_i[31:22]) && bs_if.dr_out[21:18] == 4'h0);
  endproperty
  a_user_word: assert property (p_user_word) else $error("bad user code word");

  property p_dbg_drive;
    (dbg_out_en_i && bp_hit_i && !sec_reg_i[`JCD_SEC_NO_DBG]) |=> !debug_oen_o;
  endproperty
  a_dbg_drive: assert property (p_dbg_drive) else $error("debug pin not driven");

  property p_dbg_in;
    (dbg_in_en_i && !r_reg.s2[`JCD_SY_DBG] && !sec_reg_i[`JCD_SEC_NO_DBG]) |=> dbg_req_o;
  endproperty
  a_dbg_in: assert property (p_dbg_in) else $error("debug request missed");

  property p_dbg_lock;
    s_sec_steady(`JCD_SEC_NO_DBG) |-> (debug_oen_o && !dbg_req_o);
  endproperty
  a_dbg_lock: assert property (p_dbg_lock) else $error("debug pin used while locked");

  property p_no_jtag;
    s_sec_steady(`JCD_SEC_NO_JTAG) |-> !acc_valid_o;
  endproperty
  a_no_jtag: assert property (p_no_jtag) else $error("access while scan locked");

  property p_no_otp;
    acc_valid_o |-> !($past(sec_reg_i[`JCD_SEC_NO_OTP]) && acc_tgt_o == `JCD_TGT_OTP);
  endproperty
  a_no_otp: assert property (p_no_otp) else $error("memory access while locked");

  property p_access;
    (ch_if.update_dr && ch_if.ir == `JCD_IR_ACCESS && !refuse && r_reg.s2[`JCD_SY_TRST])
      |=> (acc_valid_o ##1 !acc_valid_o);
  endproperty
  a_access: assert property (p_access) else $error("access pulse wrong");

  property p_boot;
    $rose(boot_go_o) |-> $past(r_reg.s2[`JCD_SY_LOCK]);
  endproperty
  a_boot: assert property (p_boot) else $error("boot before lock");
endmodule : jcd_top

// File: src/jcd_regs.svh
// Constants for the scan chain and debug synchronisation block.
`ifndef JCD_REGS_SVH
`define JCD_REGS_SVH
`define JCD_DR_W 32
`define JCD_LEN_W 6
`define JCD_IR_W 4
`define JCD_IR_EXTEST 4'h0
`define JCD_IR_DEVICE_IDENTIFICATION_WORD 4'h1
`define JCD_IR_SAMPLE 4'h2
`define JCD_IR_ACCESS 4'h3
`define JCD_IR_USERCODE 4'h8
`define JCD_IR_BYPASS 4'hF
`define JCD_IR_CAPTURE 4'h1
`define JCD_LEN_ID 6'h20
`define JCD_LEN_ONE 6'h01
`define JCD_BSR_W 8
`define JCD_LEN_BSR 6'h08
`define JCD_SYNC_W 16
`define JCD_SYNC_RST 16'h0010
`define JCD_SY_TCK 0
`define JCD_SY_TMS 1
`define JCD_SY_TDI 2
`define JCD_SY_TRST 3
`define JCD_SY_DBG 4
`define JCD_SY_LOCK 5
`define JCD_SY_MODE_LSB 6
`define JCD_SY_PIN_LSB 8
`define JCD_SEC_NO_JTAG 0
`define JCD_SEC_NO_OTP 13
`define JCD_SEC_NO_DBG 14
`define JCD_UID_MSB 31
`define JCD_UID_LSB 22
`define JCD_UNUSED_W 4
`define JCD_REV_W 18
`define JCD_TGT_TILE 2'h0
`define JCD_TGT_SWITCH 2'h1
`define JCD_TGT_OTP 2'h2
`define JCD_ACC_W 30
`endif

// File: src/jcd_pkg.sv
// Types shared by the scan chain modules.
package jcd_pkg;
  `include "jcd_regs.svh"

  typedef enum logic [3:0] {
    JCD_TLR = 4'hF, JCD_RTI = 4'hC, JCD_SELDR = 4'h7, JCD_CAPDR = 4'h6,
    JCD_SHDR = 4'h2, JCD_EX1DR = 4'h1, JCD_PSDR = 4'h3, JCD_EX2DR = 4'h0,
    JCD_UPDR = 4'h5, JCD_SELIR = 4'h4, JCD_CAPIR = 4'hE, JCD_SHIR = 4'hA,
    JCD_EX1IR = 4'h9, JCD_PSIR = 4'hB, JCD_EX2IR = 4'h8, JCD_UPIR = 4'hD
  } jcd_tap_state_t;

  typedef struct packed {
    jcd_tap_state_t st;
    logic [`JCD_IR_W-1:0] ir;
    logic [`JCD_IR_W-1:0] ish;
    logic [`JCD_DR_W-1:0] sh;
    logic tdo;
    logic shifting;
  } jcd_tap_st_t;

  typedef struct packed {
    logic [`JCD_SYNC_W-1:0] s1;
    logic [`JCD_SYNC_W-1:0] s2;
    logic tck_q;
    logic tdo;
    logic tdo_oen;
    logic dbg_oen;
    logic dbg_req;
    logic boot_go;
    logic [1:0] boot_mode;
    logic acc_valid;
    logic [1:0] acc_tgt;
    logic acc_wr;
    logic [`JCD_ACC_W-2:0] acc_word;
    logic refused;
    logic [`JCD_BSR_W-1:0] bsr;
    logic pin_oen;
  } jcd_top_st_t;
endpackage : jcd_pkg

// File: src/jcd_tap_if.sv
// Link between the top and one scan controller.
`timescale 1ns/10ps
`include "jcd_regs.svh"
interface jcd_tap_if;
  import jcd_pkg::*;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst_n;
  logic [`JCD_DR_W-1:0] dr_in;
  logic [`JCD_LEN_W-1:0] dr_len;
  logic tdo;
  logic shifting;
  logic tlr;
  logic capture_dr;
  logic update_dr;
  logic [`JCD_IR_W-1:0] ir;
  logic [`JCD_DR_W-1:0] dr_out;
  modport tap(input tck_rise, tck_fall, tms, tdi, trst_n, dr_in, dr_len,
    output tdo, shifting, tlr, capture_dr, update_dr, ir, dr_out);
  modport ctl(output tck_rise, tck_fall, tms, tdi, trst_n, dr_in, dr_len,
    input tdo, shifting, tlr, capture_dr, update_dr, ir, dr_out);
endinterface : jcd_tap_if

// File: src/jcd_tap.sv
// One test access port controller with instruction and data shifters.
`timescale 1ns/10ps
`include "jcd_regs.svh"
module jcd_tap
  import jcd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Controller link.
  jcd_tap_if.tap bus
);
  jcd_tap_st_t r_reg;
  jcd_tap_st_t r_next;
  logic [`JCD_DR_W-1:0] tmp;

  function automatic jcd_tap_state_t jcd_step(jcd_tap_state_t s, logic m);
    unique case (s)
      JCD_TLR: jcd_step = m ? JCD_TLR : JCD_RTI;
      JCD_RTI: jcd_step = m ? JCD_SELDR : JCD_RTI;
      JCD_SELDR: jcd_step = m ? JCD_SELIR : JCD_CAPDR;
      JCD_CAPDR: jcd_step = m ? JCD_EX1DR : JCD_SHDR;
      JCD_SHDR: jcd_step = m ? JCD_EX1DR : JCD_SHDR;
      JCD_EX1DR: jcd_step = m ? JCD_UPDR : JCD_PSDR;
      JCD_PSDR: jcd_step = m ? JCD_EX2DR : JCD_PSDR;
      JCD_EX2DR: jcd_step = m ? JCD_UPDR : JCD_SHDR;
      JCD_UPDR: jcd_step = m ? JCD_SELDR : JCD_RTI;
      JCD_SELIR: jcd_step = m ? JCD_TLR : JCD_CAPIR;
      JCD_CAPIR: jcd_step = m ? JCD_EX1IR : JCD_SHIR;
      JCD_SHIR: jcd_step = m ? JCD_EX1IR : JCD_SHIR;
      JCD_EX1IR: jcd_step = m ? JCD_UPIR : JCD_PSIR;
      JCD_PSIR: jcd_step = m ? JCD_EX2IR : JCD_PSIR;
      JCD_EX2IR: jcd_step = m ? JCD_UPIR : JCD_SHIR;
      JCD_UPIR: jcd_step = m ? JCD_SELDR : JCD_RTI;
    endcase
  endfunction : jcd_step

  always_comb begin
    tmp = '0;
    r_next = r_reg;
    if (!bus.trst_n) begin
      // A held test reset keeps the controller parked, however long.
      r_next.st = JCD_TLR;
      r_next.ir = `JCD_IR_DEVICE_IDENTIFICATION_WORD;
      r_next.shifting = 1'b0;
    end else begin
      if (bus.tck_rise) begin
        r_next.st = jcd_step(r_reg.st, bus.tms);
        unique case (r_reg.st)
          JCD_TLR: r_next.ir = `JCD_IR_DEVICE_IDENTIFICATION_WORD;
          JCD_CAPDR: r_next.sh = bus.dr_in;
          JCD_SHDR: begin
            tmp = r_reg.sh >> 1;
            tmp[5'(bus.dr_len - `JCD_LEN_ONE)] = bus.tdi;
            r_next.sh = tmp;
          end
          JCD_CAPIR: r_next.ish = `JCD_IR_CAPTURE;
          JCD_SHIR: r_next.ish = {bus.tdi, r_reg.ish[`JCD_IR_W-1:1]};
          JCD_UPIR: r_next.ir = r_reg.ish;
          default: r_next.ish = r_reg.ish;
        endcase
      end
      if (bus.tck_fall) begin
        // Output changes on the falling edge so the next stage samples it stable.
        r_next.tdo = (r_reg.st == JCD_SHIR) ? r_reg.ish[0] : r_reg.sh[0];
        r_next.shifting = (r_reg.st == JCD_SHIR) || (r_reg.st == JCD_SHDR);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '{st: JCD_TLR, ir: `JCD_IR_DEVICE_IDENTIFICATION_WORD, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.tdo = r_reg.tdo;
  assign bus.shifting = r_reg.shifting;
  assign bus.tlr = (r_reg.st == JCD_TLR);
  assign bus.ir = r_reg.ir;
  assign bus.dr_out = r_reg.sh;
  assign bus.capture_dr = bus.tck_rise && bus.trst_n && (r_reg.st == JCD_CAPDR);
  assign bus.update_dr = bus.tck_rise && bus.trst_n && (r_reg.st == JCD_UPDR);

  property p_tap_idle;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (bus.trst_n && bus.tck_rise && r_reg.st == JCD_TLR && !bus.tms) |=> (r_reg.st == JCD_RTI);
  endproperty
  a_tap_idle: assert property (p_tap_idle) else $error("tap did not leave reset state");

  property p_tap_upir;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (bus.trst_n && bus.tck_rise && r_reg.st == JCD_UPIR) |=> (r_reg.ir == $past(r_reg.ish));
  endproperty
  a_tap_upir: assert property (p_tap_upir) else $error("instruction not updated");
endmodule : jcd_tap

// File: verif/jcd_probe.sv
// Scan probe model that drives the test pins of the block.
`timescale 1ns/10ps
module jcd_probe
  import jcd_pkg::*;
(
  // Scan pins.
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic tdo_i
);
  localparam realtime HALF = 62.5;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b0;
  end
  task automatic hold(input logic v);
    trst_n_o = v;
  endtask : hold
  // One test clock period; the clock rests low outside frames.
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #HALF;
    q = tdo_i;
    tck_o = 1'b1;
    #HALF;
    tck_o = 1'b0;
  endtask : step
  // Test reset stays low well past the minimum, then the controllers are moved to idle.
  task automatic trst();
    logic q;
    hold(1'b0);
    #200;
    hold(1'b1);
    #100;
    step(1'b0, 1'b0, q);
  endtask : trst
  // Shift n bits LSB first from idle and return to idle.
  task automatic shift(input bit ir, input int n, input logic [63:0] din,
    output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    // The released data line rests high, as a pulled-up input would.
    step(1'b0, 1'b1, q);
  endtask : shift
endmodule : jcd_probe

// File: verif/tb_jcd_top.sv
// Self-checking bench for the scan chain and debug sync block.
`timescale 1ns/10ps
`include "jcd_regs.svh"
module tb_jcd_top;
  import jcd_pkg::*;
  // Identity values are arbitrary.
  localparam logic [3:0] VER = 4'h2;
  localparam logic [15:0] PART = 16'h0C5A;
  localparam logic [10:0] MAKER = 11'h0A7;
  localparam logic [17:0] REV = 18'h00103;
  localparam logic [31:0] ID_W = {VER, PART, MAKER, 1'b1};
  localparam logic [13:0] A_TGT = {2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h0};
  localparam logic [6:0] A_REF = 7'b0101000;
  localparam int LIMIT = 60000;
  logic clk_sys_i = 1'b0;
  logic nrst_i, tck, tms, tdi, trst_n, tdo, tdo_pin, tdo_oen;
  logic debug_i, debug_o, debug_oen, out_en, in_en, bp_hit, dbg_req, ext_low;
  logic pll_lock, boot_go, acc_valid, acc_wr, pins_oen;
  logic [1:0] boot_mode, boot_mode_o, acc_tgt;
  logic [31:0] sec_reg, acc_seen;
  logic [28:0] acc_word;
  logic [30:0] acc_rdata;
  logic [7:0] pins_i, pins_o;
  logic [63:0] d;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_acc = 0;
  int n_leak = 0;
  bit trst_watch = 1'b0;

  always #5 clk_sys_i = ~clk_sys_i;
  // Both pins are pulled up when nobody drives them.
  assign debug_i = !(ext_low || (!debug_oen && !debug_o));
  assign tdo_pin = tdo_oen ? 1'b1 : tdo;

  jcd_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER), .SIL_REV(REV))
  jcd_top_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oen_o(tdo_oen), .debug_i(debug_i),
    .debug_o(debug_o), .debug_oen_o(debug_oen), .dbg_out_en_i(out_en), .dbg_in_en_i(in_en),
    .bp_hit_i(bp_hit), .dbg_req_o(dbg_req), .sec_reg_i(sec_reg), .pll_lock_i(pll_lock),
    .boot_mode_i(boot_mode), .boot_go_o(boot_go), .boot_mode_o(boot_mode_o),
    .acc_valid_o(acc_valid), .acc_tgt_o(acc_tgt), .acc_wr_o(acc_wr), .acc_word_o(acc_word),
    .acc_rdata_i(acc_rdata), .pins_i(pins_i), .pins_o(pins_o), .pins_oen_o(pins_oen));
  jcd_probe jcd_probe_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(tdo_pin));

  // Outputs are watched mid-cycle, where they have settled.
  always @(negedge clk_sys_i) begin
    if (acc_valid === 1'b1) begin
      n_acc <= n_acc + 1;
      acc_seen <= {acc_tgt, acc_wr, acc_word};
    end
    if (trst_watch && (tdo_oen !== 1'b1 || pins_oen !== 1'b1)) n_leak <= n_leak + 1;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic ir(input logic [3:0] chip, input logic [3:0] bnd);
    jcd_probe_i.shift(1'b1, 8, {56'h0, bnd, chip}, d);
    check("ir capture", d[7:0], 8'h11);
  endtask : ir
  task automatic dr(input int n, input logic [63:0] din);
    jcd_probe_i.shift(1'b0, n, din, d);
    cyc(3);
  endtask : dr
  task automatic read_id();
    jcd_probe_i.trst();
    jcd_probe_i.shift(1'b0, 64, 64'h0, d);
    check("id chain", d, {ID_W, ID_W});
  endtask : read_id

  // A hang is cut short after a fixed number of clock cycles.
  initial begin
    repeat (LIMIT) @(posedge clk_sys_i);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    logic [31:0] w;
    int base;
    nrst_i = 1'b0;
    out_en = 1'b0;
    in_en = 1'b0;
    bp_hit = 1'b0;
    ext_low = 1'b0;
    sec_reg = 32'h0;
    pll_lock = 1'b0;
    boot_mode = 2'h2;
    acc_rdata = 31'h2A5A1234;
    pins_i = 8'hC3;
    repeat (10) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    cyc(6);
    check("boot before lock", boot_go, 1'b0);
    pll_lock = 1'b1;
    cyc(6);
    check("boot after lock", {boot_go, boot_mode_o}, {1'b1, 2'h2});
    read_id();
    ir(`JCD_IR_BYPASS, `JCD_IR_USERCODE);
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      sec_reg = k ? {10'h2A5, 22'h000020} : 32'h0;
      dr(33, 64'h0);
      check("user code", d[32:0], {k ? 10'h2A5 : 10'h0, 4'h0, REV, 1'b0});
    end
    ir(`JCD_IR_BYPASS, `JCD_IR_SAMPLE);
    dr(9, 64'h0);
    check("sampled pins", d[8:0], {pins_i, 1'b0});
    ir(`JCD_IR_BYPASS, `JCD_IR_EXTEST);
    dr(9, {55'h0, 8'h3C, 1'b0});
    check("driven pins", {pins_oen, pins_o}, {1'b0, 8'h3C});
    // Refused accesses leave no request and flag the next capture.
    ir(`JCD_IR_ACCESS, `JCD_IR_BYPASS);
    for (int k = 0; k < 7; k++) begin
      cyc(1);
      sec_reg = (k == 5) ? 32'h1 : ((k == 3 || k == 4) ? 32'h2000 : 32'h0);
      w = {A_TGT[2*k +: 2], k[0], 29'h0ABC000 + 29'(k)};
      base = n_acc;
      dr(33, {32'h0, w});
      check("access read data", d[30:0], acc_rdata);
      if (k > 0) check("refused flag", d[31], A_REF[k-1]);
      check("access count", n_acc - base, !A_REF[k]);
      if (!A_REF[k]) check("access word", acc_seen, w);
    end
    for (int k = 0; k < 16; k++) begin
      out_en = !k[3] && k[1];
      bp_hit = k[3] || k[2];
      in_en = k[3] && k[1];
      ext_low = k[3] && k[2];
      sec_reg = {17'h0, k[0], 14'h0};
      cyc(6);
      check("debug drive", debug_oen, !(out_en && bp_hit && !k[0]));
      check("debug request", dbg_req, in_en && ext_low && !k[0]);
    end
    check("debug pin level", debug_o, 1'b0);
    jcd_probe_i.hold(1'b0);
    cyc(5);
    trst_watch = 1'b1;
    jcd_probe_i.shift(1'b1, 8, 64'h0, d);
    jcd_probe_i.shift(1'b0, 33, 64'h0, d);
    trst_watch = 1'b0;
    check("test reset leaks", n_leak, 0);
    read_id();
    out_en = 1'b1;
    bp_hit = 1'b1;
    in_en = 1'b0;
    ext_low = 1'b0;
    sec_reg = 32'h0;
    cyc(6);
    // Global reset is applied between clock edges on purpose.
    #2;
    nrst_i = 1'b0;
    #1;
    check("reset takes hold", {boot_go, debug_oen, tdo_oen}, 3'b011);
    cyc(3);
    end_of_test();
  end
endmodule : tb_jcd_top
